// ### tlic_core_model.sv
module tlic_core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic vector_req,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] ack_delay,
  input wire logic ret_go,
  output logic vector_ack,
  output logic return_from_service_instr,
  output logic [15:0] pc_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stack_r [0:3];
  logic [1:0] sp_r;
  logic [3:0] wait_r;
  always @(posedge clock) begin
    if (rst) begin
      vector_ack <= 1'b0;
      return_from_service_instr <= 1'b0;
      pc_r <= 16'h0100;
      sp_r <= 2'h0;
      wait_r <= 4'h0;
    end else begin
      return_from_service_instr <= ret_go;
      if (vector_ack) begin
        vector_ack <= 1'b0;
        wait_r <= 4'h0;
      end else if (vector_req && wait_r >= ack_delay) begin
        vector_ack <= 1'b1;
        stack_r[sp_r] <= pc_r;
        sp_r <= sp_r + 2'h1;
        pc_r <= vector_addr;
      end else if (vector_req) begin
        wait_r <= wait_r + 4'h1;
      end
      if (ret_go) begin
        sp_r <= sp_r - 2'h1;
        pc_r <= stack_r[sp_r-2'h1];
      end
    end
  end
endmodule : tlic_core_model

// ### tlic_ctrl.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`include "tlic_defs.svh"
// How it works
// - priority mode vectors: high to 0008h, low to 0018h
// - enabled high event preempts a running low-priority routine
// - per-source flag, enable, priority; disabled source never branches
// - priority mode only while mode register bit 7 set
// - priority mode: bit 7 gates high and low sources, bit 6 low sources
// - flag, enable and matching global enable force branch immediately
// - compatibility mode ignores per-source priority bits
// - compatibility: bit 6 peripheral enable, bit 7 master enable
// - compatibility: every accepted interrupt vectors to 0008h
// - accepting clears the global enable that admitted it
// - low requests held off while high routine runs
// - core pushes return address and loads vector on accept
// - return instruction exits routine and sets applicable enable
// - external event to vector latency three to four cycles
// - flags set on events regardless of any enable
module tlic_ctrl
  import tlic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] external_pin_irq,
  input wire logic [3:0] periph_event,
  input wire logic vector_ack,
  input wire logic return_from_service_instr,
  output logic vector_req,
  output logic [15:0] vector_addr
);
  logic [7:0] irq_control_reg_r;
  logic [7:0] reset_control_reg_r;
  logic [7:0] flag_r;
  logic [7:0] enab_r;
  logic [7:0] prio_r;
  tlic_state_t state_r;
  tlic_state_t state_nxt;
  tlic_vec_t vec_r;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev_r;
  logic [7:0] events;
  logic priority_mode_enable;
  logic high_level_global_enable;
  logic low_level_global_enable;
  logic master_irq_enable;
  logic peripheral_irq_enable;
  logic [7:0] active;
  logic [7:0] active_high;
  logic [7:0] active_low;
  logic any_high;
  logic any_low;
  logic cmp_take;
  logic take_high;
  logic take_low;
  logic accept;
  logic accept_high;
  logic [31:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic do_write;
  logic [7:0] wr_byte;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_flag;
  logic wr_enab;
  logic wr_prio;
  logic wr_hit;
  logic rd_take;
  logic rd_hit;
  logic [7:0] rd_byte;

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ref_a);
    addr_is = (a[7:2] == ref_a[7:2]) && (a[31:8] == 24'h00_0000);
  endfunction : addr_is

  logic [7:0] pin_sync_full;
  tlic_sync u_tlic_sync (
    .clock(clock),
    .rst(rst),
    .async_in({4'h0, external_pin_irq}),
    .sync_out(pin_sync_full)
  );
  assign pin_sync = pin_sync_full[3:0];

  // rising edge on a synchronised pin is the event
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_prev_r <= 4'h0;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end
  assign events = {periph_event, pin_sync & ~pin_prev_r};

  assign priority_mode_enable = reset_control_reg_r[`TLIC_MODE_PRIO_BIT];
  assign high_level_global_enable = irq_control_reg_r[`TLIC_CTRL_HI_BIT];
  assign low_level_global_enable = irq_control_reg_r[`TLIC_CTRL_LO_BIT];
  assign master_irq_enable = irq_control_reg_r[`TLIC_CTRL_HI_BIT];
  assign peripheral_irq_enable = irq_control_reg_r[`TLIC_CTRL_LO_BIT];

  assign active = flag_r & enab_r;
  assign active_high = active & prio_r;
  assign active_low = active & ~prio_r;
  assign any_high = |active_high;
  assign any_low = |active_low;
  // pins need master only, peripherals also bit 6
  assign cmp_take = master_irq_enable &&
                    ((|(active & `TLIC_EXT_MASK)) ||
                     (peripheral_irq_enable && (|(active & ~`TLIC_EXT_MASK))));
  // high allowed during low service; low held off during high
  assign take_high = priority_mode_enable && high_level_global_enable && any_high &&
                     (state_r == TLIC_IDLE || state_r == TLIC_SVC_LOW);
  assign take_low = priority_mode_enable && low_level_global_enable && any_low &&
                    high_level_global_enable && state_r == TLIC_IDLE;
  assign accept = !vec_r.req && (take_high || take_low ||
                  (!priority_mode_enable && cmp_take && state_r == TLIC_IDLE));
  // high wins a tie; compatibility always high vector
  assign accept_high = take_high || !priority_mode_enable;

  always_comb begin
    state_nxt = state_r;
    if (accept) begin
      if (!priority_mode_enable) begin
        state_nxt = TLIC_SVC_HIGH;
      end else if (accept_high) begin
        state_nxt = (state_r == TLIC_SVC_LOW) ? TLIC_SVC_BOTH : TLIC_SVC_HIGH;
      end else begin
        state_nxt = TLIC_SVC_LOW;
      end
    end else if (return_from_service_instr) begin
      unique case (state_r)
        TLIC_IDLE: state_nxt = TLIC_IDLE;
        TLIC_SVC_LOW: state_nxt = TLIC_IDLE;
        TLIC_SVC_HIGH: state_nxt = TLIC_IDLE;
        TLIC_SVC_BOTH: state_nxt = TLIC_SVC_LOW;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= TLIC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // vector held until the core takes it
  always_ff @(posedge clock) begin
    if (rst) begin
      vec_r <= '{req: 1'b0, addr: 16'h0000};
    end else if (accept) begin
      vec_r <= '{req: 1'b1, addr: accept_high ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW};
    end else if (vector_ack) begin
      vec_r.req <= 1'b0;
    end
  end
  assign vector_req = vec_r.req;
  assign vector_addr = vec_r.addr;

  // register bus
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_byte = w_data_r[7:0];
  assign wr_ctrl = do_write && w_strb_r[0] && addr_is(aw_addr_r, `TLIC_ADDR_CTRL);
  assign wr_mode = do_write && w_strb_r[0] && addr_is(aw_addr_r, `TLIC_ADDR_MODE);
  assign wr_flag = do_write && w_strb_r[0] && addr_is(aw_addr_r, `TLIC_ADDR_FLAG);
  assign wr_enab = do_write && w_strb_r[0] && addr_is(aw_addr_r, `TLIC_ADDR_ENAB);
  assign wr_prio = do_write && w_strb_r[0] && addr_is(aw_addr_r, `TLIC_ADDR_PRIO);
  assign wr_hit = addr_is(aw_addr_r, `TLIC_ADDR_CTRL) || addr_is(aw_addr_r, `TLIC_ADDR_MODE) ||
                  addr_is(aw_addr_r, `TLIC_ADDR_FLAG) || addr_is(aw_addr_r, `TLIC_ADDR_ENAB) ||
                  addr_is(aw_addr_r, `TLIC_ADDR_PRIO) || addr_is(aw_addr_r, `TLIC_ADDR_STAT);

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TLIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // accept clears admitting enable; return sets it
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_control_reg_r <= `TLIC_CTRL_RST;
    end else if (accept) begin
      if (accept_high) begin
        irq_control_reg_r[`TLIC_CTRL_HI_BIT] <= 1'b0;
      end else begin
        irq_control_reg_r[`TLIC_CTRL_LO_BIT] <= 1'b0;
      end
    end else if (return_from_service_instr && state_r != TLIC_IDLE) begin
      if (state_r == TLIC_SVC_LOW) begin
        irq_control_reg_r[`TLIC_CTRL_LO_BIT] <= 1'b1;
      end else begin
        irq_control_reg_r[`TLIC_CTRL_HI_BIT] <= 1'b1;
      end
    end else if (wr_ctrl) begin
      irq_control_reg_r <= {wr_byte[7:6], 6'h00};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_control_reg_r <= `TLIC_MODE_RST;
      enab_r <= `TLIC_ENAB_RST;
      prio_r <= `TLIC_PRIO_RST;
    end else begin
      if (wr_mode) begin
        reset_control_reg_r <= {wr_byte[7], 7'h00};
      end
      if (wr_enab) begin
        enab_r <= wr_byte;
      end
      if (wr_prio) begin
        prio_r <= wr_byte;
      end
    end
  end

  // events set flags regardless of enables; set beats clear
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_r <= `TLIC_FLAG_RST;
    end else if (wr_flag) begin
      flag_r <= (flag_r & wr_byte) | events;
    end else begin
      flag_r <= flag_r | events;
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit = addr_is(s_axi_araddr, `TLIC_ADDR_CTRL) ||
                  addr_is(s_axi_araddr, `TLIC_ADDR_MODE) ||
                  addr_is(s_axi_araddr, `TLIC_ADDR_FLAG) ||
                  addr_is(s_axi_araddr, `TLIC_ADDR_ENAB) ||
                  addr_is(s_axi_araddr, `TLIC_ADDR_PRIO) ||
                  addr_is(s_axi_araddr, `TLIC_ADDR_STAT);
  assign rd_byte = addr_is(s_axi_araddr, `TLIC_ADDR_CTRL) ? irq_control_reg_r :
                   addr_is(s_axi_araddr, `TLIC_ADDR_MODE) ? reset_control_reg_r :
                   addr_is(s_axi_araddr, `TLIC_ADDR_FLAG) ? flag_r :
                   addr_is(s_axi_araddr, `TLIC_ADDR_ENAB) ? enab_r :
                   addr_is(s_axi_araddr, `TLIC_ADDR_PRIO) ? prio_r :
                   addr_is(s_axi_araddr, `TLIC_ADDR_STAT) ? {5'h00, vec_r.req, state_r} :
                   8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TLIC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  hi_vec_a: assert property (@(posedge clock) disable iff (rst)
    accept && priority_mode_enable && take_high |=> vector_req && vector_addr == 16'h0008)
    else $error("high vector wrong");
  lo_vec_a: assert property (@(posedge clock) disable iff (rst)
    accept && priority_mode_enable && !take_high |=> vector_addr == 16'h0018)
    else $error("low vector wrong");
  cmp_vec_a: assert property (@(posedge clock) disable iff (rst)
    accept && !priority_mode_enable |=> vector_addr == 16'h0008)
    else $error("compat vector wrong");
  gie_clear_a: assert property (@(posedge clock) disable iff (rst)
    accept && accept_high |=> !irq_control_reg_r[7])
    else $error("global enable not cleared");
  low_hold_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == TLIC_SVC_HIGH || state_r == TLIC_SVC_BOTH) |=>
    !(vector_req && vector_addr == 16'h0018))
    else $error("low taken during high");
  preempt_a: assert property (@(posedge clock) disable iff (rst)
    state_r == TLIC_SVC_LOW && take_high && !vec_r.req |=> state_r == TLIC_SVC_BOTH)
    else $error("no preemption");
  flag_set_a: assert property (@(posedge clock) disable iff (rst)
    events[4] |=> flag_r[4])
    else $error("flag not set");
  pin_lat_a: assert property (@(posedge clock) disable iff (rst)
    $rose(external_pin_irq[0]) ##0 (!vector_req && !flag_r[0] && enab_r[0] &&
    master_irq_enable && (priority_mode_enable ?
    (prio_r[0] && (state_r == TLIC_IDLE || state_r == TLIC_SVC_LOW)) :
    state_r == TLIC_IDLE))[*1] ##1
    (!return_from_service_instr && !wr_ctrl && !wr_flag && !wr_enab && !wr_mode &&
    !wr_prio)[*3]
    |-> ##[0:1] vector_req)
    else $error("pin latency exceeded");
  ret_set_a: assert property (@(posedge clock) disable iff (rst)
    return_from_service_instr && !accept && state_r == TLIC_SVC_HIGH |=> irq_control_reg_r[7])
    else $error("return did not re-enable");
  dis_src_a: assert property (@(posedge clock) disable iff (rst)
    enab_r == 8'h00 |-> !accept)
    else $error("disabled source accepted");
  hi_cov_c: cover property (@(posedge clock) accept && take_high);
  lo_cov_c: cover property (@(posedge clock) accept && take_low);
  pre_cov_c: cover property (@(posedge clock) state_r == TLIC_SVC_BOTH);
  cmp_cov_c: cover property (@(posedge clock) accept && !priority_mode_enable);
endmodule : tlic_ctrl

// ### tlic_ctrl_tb.sv
`include "tlic_defs.svh"
module tlic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, external_pin_irq, periph_event, ack_delay;
  logic vector_ack, return_from_service_instr, vector_req, ret_go;
  logic [15:0] vector_addr, pc_r;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  tlic_ctrl u_tlic_ctrl (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .external_pin_irq(external_pin_irq),
    .periph_event(periph_event), .vector_ack(vector_ack),
    .return_from_service_instr(return_from_service_instr), .vector_req(vector_req),
    .vector_addr(vector_addr));
  tlic_core_model u_tlic_core_model (.clock(clock), .rst(rst), .vector_req(vector_req),
    .vector_addr(vector_addr), .ack_delay(ack_delay), .ret_go(ret_go),
    .vector_ack(vector_ack), .return_from_service_instr(return_from_service_instr),
    .pc_r(pc_r));
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic guard(input int k);
    if (k > 200) begin
      n_mismatch++;
      $display("MISMATCH wait_bound exp done got timeout");
      final_report();
    end
  endtask : guard
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      k++;
      guard(k);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      k++;
      guard(k);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    chk($sformatf("rresp_%h", a), {30'h0, er}, {30'h0, s_axi_rresp});
    if (er === `TLIC_RESP_OKAY) chk($sformatf("rdata_%h", a), d, s_axi_rdata);
  endtask : rd
  task automatic wait_vec(input logic [15:0] va);
    int k;
    k = 0;
    while (vector_req !== 1'b1) begin
      @(posedge clock);
      k++;
      guard(k);
    end
    chk("vector_addr", {16'h0, va}, {16'h0, vector_addr});
    while (vector_req !== 1'b0) begin
      @(posedge clock);
      k++;
      guard(k);
    end
    @(posedge clock);
    chk("core_pc", {16'h0, va}, {16'h0, pc_r});
  endtask : wait_vec
  task automatic quiet(input int k);
    logic seen;
    seen = 1'b0;
    repeat (k) begin
      @(posedge clock);
      seen = seen | (vector_req !== 1'b0);
    end
    chk("no_vector", 32'h0, {31'h0, seen});
  endtask : quiet
  task automatic ev(input logic [3:0] b);
    @(posedge clock);
    periph_event <= b;
    @(posedge clock);
    periph_event <= 4'h0;
  endtask : ev
  task automatic ret(input logic [15:0] pc_e);
    @(posedge clock);
    ret_go <= 1'b1;
    @(posedge clock);
    ret_go <= 1'b0;
    repeat (3) @(posedge clock);
    chk("return_pc", {16'h0, pc_e}, {16'h0, pc_r});
  endtask : ret
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_araddr = 32'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    external_pin_irq = 4'h0;
    periph_event = 4'h0;
    ack_delay = 4'h3;
    ret_go = 1'b0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(`TLIC_ADDR_CTRL, 32'h0000_0000, `TLIC_RESP_OKAY);
    rd(`TLIC_ADDR_MODE, 32'h0000_0000, `TLIC_RESP_OKAY);
    rd(`TLIC_ADDR_FLAG, 32'h0000_0000, `TLIC_RESP_OKAY);
    rd(`TLIC_ADDR_ENAB, 32'h0000_0000, `TLIC_RESP_OKAY);
    rd(`TLIC_ADDR_PRIO, 32'h0000_00FF, `TLIC_RESP_OKAY);
    rd(32'h0000_0018, 32'h0000_0000, `TLIC_RESP_SLVERR);
    wr(32'h0000_0018, 32'h0000_00FF, `TLIC_RESP_SLVERR);
    wr(`TLIC_ADDR_CTRL, 32'h0000_00C0, `TLIC_RESP_OKAY);
    ev(4'h4);
    quiet(20);
    rd(`TLIC_ADDR_FLAG, 32'h0000_0040, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_FLAG, 32'h0000_0000, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_CTRL, 32'h0000_0000, `TLIC_RESP_OKAY);
    // mode bits other than bit 7 leave compatibility mode on
    wr(`TLIC_ADDR_MODE, 32'h0000_007F, `TLIC_RESP_OKAY);
    rd(`TLIC_ADDR_MODE, 32'h0000_0000, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_PRIO, 32'h0000_0000, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_ENAB, 32'h0000_00F0, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_CTRL, 32'h0000_0080, `TLIC_RESP_OKAY);
    ev(4'h1);
    quiet(20);
    wr(`TLIC_ADDR_CTRL, 32'h0000_00C0, `TLIC_RESP_OKAY);
    wait_vec(`TLIC_VEC_HIGH);
    rd(`TLIC_ADDR_CTRL, 32'h0000_0040, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_FLAG, 32'h0000_0000, `TLIC_RESP_OKAY);
    ret(16'h0100);
    rd(`TLIC_ADDR_CTRL, 32'h0000_00C0, `TLIC_RESP_OKAY);
    ack_delay <= 4'h0;
    wr(`TLIC_ADDR_CTRL, 32'h0000_0000, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_MODE, 32'h0000_0080, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_PRIO, 32'h0000_002F, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_ENAB, 32'h0000_00FF, `TLIC_RESP_OKAY);
    ev(4'h3);
    wr(`TLIC_ADDR_CTRL, 32'h0000_00C0, `TLIC_RESP_OKAY);
    wait_vec(`TLIC_VEC_HIGH);
    rd(`TLIC_ADDR_CTRL, 32'h0000_0040, `TLIC_RESP_OKAY);
    quiet(20);
    wr(`TLIC_ADDR_FLAG, 32'h0000_00DF, `TLIC_RESP_OKAY);
    ret(16'h0100);
    wait_vec(`TLIC_VEC_LOW);
    rd(`TLIC_ADDR_CTRL, 32'h0000_0080, `TLIC_RESP_OKAY);
    wr(`TLIC_ADDR_FLAG, 32'h0000_00EF, `TLIC_RESP_OKAY);
    n = 0;
    @(posedge clock);
    external_pin_irq <= 4'h1;
    do begin
      @(posedge clock);
      n++;
    end while (vector_req !== 1'b1 && n < 20);
    // the request is seen one edge after the edge that raises it
    chk("pin_latency_3_to_4", 32'h1, {31'h0, (n - 1) >= 3 && (n - 1) <= 4});
    wait_vec(`TLIC_VEC_HIGH);
    rd(`TLIC_ADDR_CTRL, 32'h0000_0000, `TLIC_RESP_OKAY);
    rd(`TLIC_ADDR_STAT, {29'h0000_0000, 1'b0, tlic_pkg::TLIC_SVC_BOTH}, `TLIC_RESP_OKAY);
    external_pin_irq <= 4'h0;
    wr(`TLIC_ADDR_FLAG, 32'h0000_00FE, `TLIC_RESP_OKAY);
    ret(`TLIC_VEC_LOW);
    rd(`TLIC_ADDR_CTRL, 32'h0000_0080, `TLIC_RESP_OKAY);
    ret(16'h0100);
    rd(`TLIC_ADDR_CTRL, 32'h0000_00C0, `TLIC_RESP_OKAY);
    quiet(10);
    final_report();
  end
endmodule : tlic_ctrl_tb

// ### tlic_defs.svh
`ifndef TLIC_DEFS_SVH
`define TLIC_DEFS_SVH
`define TLIC_ADDR_CTRL 32'h0000_0000
`define TLIC_ADDR_MODE 32'h0000_0004
`define TLIC_ADDR_FLAG 32'h0000_0008
`define TLIC_ADDR_ENAB 32'h0000_000C
`define TLIC_ADDR_PRIO 32'h0000_0010
`define TLIC_ADDR_STAT 32'h0000_0014
`define TLIC_CTRL_HI_BIT 7
`define TLIC_CTRL_LO_BIT 6
`define TLIC_MODE_PRIO_BIT 7
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_CTRL_RST 8'h00
`define TLIC_MODE_RST 8'h00
`define TLIC_FLAG_RST 8'h00
`define TLIC_ENAB_RST 8'h00
`define TLIC_PRIO_RST 8'hFF
`define TLIC_EXT_MASK 8'h0F
`define TLIC_LAT_CYC 3
`define TLIC_RESP_OKAY 2'b00
`define TLIC_RESP_SLVERR 2'b10
`endif

// ### tlic_pkg.sv
package tlic_pkg;
  typedef enum logic [1:0] {
    TLIC_IDLE = 2'b00,
    TLIC_SVC_LOW = 2'b01,
    TLIC_SVC_HIGH = 2'b10,
    TLIC_SVC_BOTH = 2'b11
  } tlic_state_t;
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } tlic_vec_t;
endpackage : tlic_pkg

// ### tlic_sync.sv
module tlic_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  logic [7:0] meta_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : tlic_sync
